// File: amd_cfg.svh
`ifndef AMD_CFG_SVH
`define AMD_CFG_SVH

// ****************************************
// Prebyte codes
// ****************************************
`define AMD_PRE_Y        8'h90
`define AMD_PRE_IND_Y    8'h91
`define AMD_PRE_IND      8'h92
`define AMD_PRE_NONE     8'h00

// ****************************************
// Opcode map columns (high nibble)
// ****************************************
`define AMD_HI_BTJ       4'h0
`define AMD_HI_BIT       4'h1
`define AMD_HI_JR        4'h2
`define AMD_HI_RMW_DIR   4'h3
`define AMD_HI_RMW_A     4'h4
`define AMD_HI_RMW_X     4'h5
`define AMD_HI_RMW_IDXS  4'h6
`define AMD_HI_RMW_IDX0  4'h7
`define AMD_HI_MISC0     4'h8
`define AMD_HI_MISC1     4'h9
`define AMD_HI_IMM       4'ha
`define AMD_HI_DIRS      4'hb
`define AMD_HI_DIRL      4'hc
`define AMD_HI_IDXL      4'hd
`define AMD_HI_IDXS      4'he
`define AMD_HI_IDX0      4'hf
`define AMD_OP_RELATIVE_SUBROUTINE_CALL     8'had
`define AMD_OP_MUL       8'h42

// ****************************************
// Address constants and reset values
// ****************************************
`define AMD_PAGE0_HI     8'h00
`define AMD_SHORT_MAX    16'h01fe
`define AMD_ADDR_RST     16'h0000
`define AMD_BYTE_RST     8'h00
`define AMD_LEN_MIN      3'h1
`define AMD_LEN_MAX      3'h4

`endif

// File: amd_pkg.sv
package amd_pkg;

    typedef enum logic [4:0] {
        AMD_M_INH, AMD_M_IMM, AMD_M_DIR_S, AMD_M_DIR_L, AMD_M_IDX0, AMD_M_IDX_S,
        AMD_M_IDX_L, AMD_M_IND_S, AMD_M_IND_L, AMD_M_INDIDX_S, AMD_M_INDIDX_L,
        AMD_M_REL_D, AMD_M_REL_I, AMD_M_BIT_D, AMD_M_BIT_I, AMD_M_BITREL_D, AMD_M_BITREL_I
    } amd_mode_t;

    typedef enum logic [3:0] {
        AMD_G_LOAD, AMD_G_STACK, AMD_G_INCDEC, AMD_G_CMP, AMD_G_LOGIC, AMD_G_BIT,
        AMD_G_BTJ, AMD_G_ARITH, AMD_G_SHIFT, AMD_G_JUMP, AMD_G_CBRANCH, AMD_G_INT, AMD_G_FLAG
    } amd_group_t;

    typedef enum logic [2:0] {
        AMD_S_IDLE, AMD_S_OP, AMD_S_B1, AMD_S_B2, AMD_S_PH, AMD_S_PL, AMD_S_FIN
    } amd_state_t;

endpackage

// File: amd_classify.sv
`timescale 1ns/100ps
`default_nettype none
`include "amd_cfg.svh"

module amd_classify
    import amd_pkg::*;
(
    // Instruction bytes
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] prebyte,
    // Decode results
    output amd_mode_t       mode,
    output amd_group_t      group,
    output logic [1:0]      n_extra,
    output logic            ptr_rd,
    output logic            ptr_word,
    output logic            use_y
);

    logic [3:0] hi;
    logic [3:0] lo;
    logic       p_ind;
    logic       p_iy;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];
    assign p_ind = (prebyte == `AMD_PRE_IND);
    assign p_iy  = (prebyte == `AMD_PRE_IND_Y);
    assign use_y = (prebyte == `AMD_PRE_Y) || p_iy;

    // ****************************************
    // Addressing mode
    // ****************************************
    always_comb begin
        mode = AMD_M_INH;
        n_extra = 2'd0;
        ptr_rd = 1'b0;
        ptr_word = 1'b0;
        unique case (hi)
            `AMD_HI_BTJ: begin
                mode = p_ind ? AMD_M_BITREL_I : AMD_M_BITREL_D;
                n_extra = 2'd2;
                ptr_rd = p_ind;
            end
            `AMD_HI_BIT: begin
                mode = p_ind ? AMD_M_BIT_I : AMD_M_BIT_D;
                n_extra = 2'd1;
                ptr_rd = p_ind;
            end
            `AMD_HI_JR: begin
                mode = p_ind ? AMD_M_REL_I : AMD_M_REL_D;
                n_extra = 2'd1;
                ptr_rd = p_ind;
            end
            // Read-modify-write has no long column at all
            `AMD_HI_RMW_DIR, `AMD_HI_DIRS: begin
                mode = p_ind ? AMD_M_IND_S : AMD_M_DIR_S;
                n_extra = 2'd1;
                ptr_rd = p_ind;
            end
            `AMD_HI_RMW_IDXS, `AMD_HI_IDXS: begin
                mode = (p_ind || p_iy) ? AMD_M_INDIDX_S : AMD_M_IDX_S;
                n_extra = 2'd1;
                ptr_rd = p_ind || p_iy;
            end
            `AMD_HI_RMW_IDX0, `AMD_HI_IDX0: begin
                mode = AMD_M_IDX0;
            end
            `AMD_HI_IMM: begin
                mode = (opcode == `AMD_OP_RELATIVE_SUBROUTINE_CALL) ? (p_ind ? AMD_M_REL_I : AMD_M_REL_D) : AMD_M_IMM;
                n_extra = 2'd1;
                ptr_rd = p_ind && (opcode == `AMD_OP_RELATIVE_SUBROUTINE_CALL);
            end
            `AMD_HI_DIRL: begin
                mode = p_ind ? AMD_M_IND_L : AMD_M_DIR_L;
                n_extra = p_ind ? 2'd1 : 2'd2;
                ptr_rd = p_ind;
                ptr_word = p_ind;
            end
            `AMD_HI_IDXL: begin
                mode = (p_ind || p_iy) ? AMD_M_INDIDX_L : AMD_M_IDX_L;
                n_extra = (p_ind || p_iy) ? 2'd1 : 2'd2;
                ptr_rd = p_ind || p_iy;
                ptr_word = p_ind || p_iy;
            end
            default: begin
                mode = AMD_M_INH;
            end
        endcase
    end

    // ****************************************
    // Functional group
    // ****************************************
    always_comb begin
        group = AMD_G_LOAD;
        if (hi == `AMD_HI_BTJ) begin
            group = AMD_G_BTJ;
        end else if (hi == `AMD_HI_BIT) begin
            group = AMD_G_BIT;
        end else if (hi == `AMD_HI_JR) begin
            group = (lo[3:1] == 3'd0) ? AMD_G_JUMP : AMD_G_CBRANCH;
        end else if (opcode == `AMD_OP_MUL) begin
            group = AMD_G_ARITH;
        end else if (hi <= `AMD_HI_RMW_IDX0) begin
            unique case (lo)
                4'h0, 4'h3: group = AMD_G_LOGIC;
                4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'he: group = AMD_G_SHIFT;
                4'ha, 4'hc: group = AMD_G_INCDEC;
                4'hd: group = AMD_G_CMP;
                default: group = AMD_G_LOAD;
            endcase
        end else if (hi <= `AMD_HI_MISC1) begin
            unique case (opcode[4:0])
                5'h00, 5'h03, 5'h0e, 5'h0f: group = AMD_G_INT;
                5'h01, 5'h1d: group = AMD_G_JUMP;
                5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h1c: group = AMD_G_STACK;
                5'h18, 5'h19, 5'h1a, 5'h1b: group = AMD_G_FLAG;
                default: group = AMD_G_LOAD;
            endcase
        end else if (opcode == `AMD_OP_RELATIVE_SUBROUTINE_CALL) begin
            group = AMD_G_JUMP;
        end else begin
            unique case (lo)
                4'h0, 4'h2, 4'h9, 4'hb: group = AMD_G_ARITH;
                4'h1, 4'h3, 4'h5: group = AMD_G_CMP;
                4'h4, 4'h8, 4'ha: group = AMD_G_LOGIC;
                4'hc, 4'hd: group = AMD_G_JUMP;
                default: group = AMD_G_LOAD;
            endcase
        end
    end

endmodule
`default_nettype wire

// File: amd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "amd_cfg.svh"

module amd_decoder
    import amd_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Decode request
    input  wire logic        START,
    input  wire logic [15:0] PC_IN,
    input  wire logic [7:0]  X_IN,
    input  wire logic [7:0]  Y_IN,
    // Memory read port
    output logic             MEM_REQ,
    output logic [15:0]      MEM_ADDR,
    input  wire logic        MEM_ACK,
    input  wire logic [7:0]  MEM_RDATA,
    // Decode result
    output logic             BUSY,
    output logic             DONE,
    output logic [15:0]      EA,
    output logic [15:0]      REL_TARGET,
    output logic [15:0]      NEXT_PC,
    output logic [7:0]       OPCODE,
    output logic [7:0]       PREBYTE,
    output logic [4:0]       MODE,
    output logic [3:0]       GROUP,
    output logic [2:0]       LENGTH,
    output logic             USE_Y
);

    // ****************************************
    // Declarations
    // ****************************************
    amd_state_t  state_q;
    logic [15:0] pc_q;
    logic [7:0]  pre_q;
    logic [7:0]  op_q;
    logic [7:0]  b1_q;
    logic [7:0]  b2_q;
    logic [7:0]  ph_q;
    logic [7:0]  pl_q;
    logic [7:0]  x_q;
    logic [7:0]  y_q;
    logic [7:0]  op_sel;
    amd_mode_t   mode;
    amd_group_t  group;
    logic [1:0]  n_extra;
    logic        ptr_rd;
    logic        ptr_word;
    logic        use_y;
    logic [7:0]  idx;
    logic        take;
    logic        is_pre;
    logic [15:0] pc_inc;
    logic [15:0] ea_d;
    logic [7:0]  rel_off;
    logic        is_rel;
    logic [2:0]  len_d;

    // Opcode is classified the cycle it arrives
    assign op_sel = (state_q == AMD_S_OP) ? MEM_RDATA : op_q;

    amd_classify u_classify (
        .opcode   (op_sel),
        .prebyte  (pre_q),
        .mode     (mode),
        .group    (group),
        .n_extra  (n_extra),
        .ptr_rd   (ptr_rd),
        .ptr_word (ptr_word),
        .use_y    (use_y)
    );

    assign idx    = use_y ? y_q : x_q;
    assign take   = MEM_REQ && MEM_ACK;
    assign pc_inc = pc_q + 16'h0001;
    assign is_pre = (MEM_RDATA == `AMD_PRE_Y) || (MEM_RDATA == `AMD_PRE_IND_Y)
                  || (MEM_RDATA == `AMD_PRE_IND);
    assign len_d  = ((pre_q != `AMD_PRE_NONE) ? 3'd2 : 3'd1) + {1'b0, n_extra};

    // ****************************************
    // Fetch sequencer
    // ****************************************
    // A second prebyte is taken as the opcode; only one may lead
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q  <= AMD_S_IDLE;
            pc_q     <= `AMD_ADDR_RST;
            pre_q    <= `AMD_PRE_NONE;
            op_q     <= `AMD_BYTE_RST;
            b1_q     <= `AMD_BYTE_RST;
            b2_q     <= `AMD_BYTE_RST;
            ph_q     <= `AMD_BYTE_RST;
            pl_q     <= `AMD_BYTE_RST;
            x_q      <= `AMD_BYTE_RST;
            y_q      <= `AMD_BYTE_RST;
            MEM_REQ  <= 1'b0;
            MEM_ADDR <= `AMD_ADDR_RST;
        end else begin
            unique case (state_q)
                AMD_S_IDLE: begin
                    if (START) begin
                        pc_q     <= PC_IN;
                        pre_q    <= `AMD_PRE_NONE;
                        b1_q     <= `AMD_BYTE_RST;
                        b2_q     <= `AMD_BYTE_RST;
                        ph_q     <= `AMD_BYTE_RST;
                        pl_q     <= `AMD_BYTE_RST;
                        x_q      <= X_IN;
                        y_q      <= Y_IN;
                        MEM_ADDR <= PC_IN;
                        MEM_REQ  <= 1'b1;
                        state_q  <= AMD_S_OP;
                    end
                end
                AMD_S_OP: begin
                    if (take) begin
                        pc_q <= pc_inc;
                        MEM_ADDR <= pc_inc;
                        if (is_pre && (pre_q == `AMD_PRE_NONE)) begin
                            pre_q <= MEM_RDATA;
                        end else begin
                            op_q <= MEM_RDATA;
                            if (n_extra != 2'd0) begin
                                state_q <= AMD_S_B1;
                            end else begin
                                MEM_REQ <= 1'b0;
                                state_q <= AMD_S_FIN;
                            end
                        end
                    end
                end
                AMD_S_B1: begin
                    if (take) begin
                        b1_q <= MEM_RDATA;
                        pc_q <= pc_inc;
                        if (n_extra == 2'd2) begin
                            MEM_ADDR <= pc_inc;
                            state_q  <= AMD_S_B2;
                        end else if (ptr_rd) begin
                            MEM_ADDR <= {`AMD_PAGE0_HI, MEM_RDATA};
                            state_q  <= AMD_S_PH;
                        end else begin
                            MEM_REQ <= 1'b0;
                            state_q <= AMD_S_FIN;
                        end
                    end
                end
                AMD_S_B2: begin
                    if (take) begin
                        b2_q <= MEM_RDATA;
                        pc_q <= pc_inc;
                        if (ptr_rd) begin
                            MEM_ADDR <= {`AMD_PAGE0_HI, b1_q};
                            state_q  <= AMD_S_PH;
                        end else begin
                            MEM_REQ <= 1'b0;
                            state_q <= AMD_S_FIN;
                        end
                    end
                end
                AMD_S_PH: begin
                    if (take) begin
                        ph_q <= MEM_RDATA;
                        if (ptr_word) begin
                            MEM_ADDR <= MEM_ADDR + 16'h0001;
                            state_q  <= AMD_S_PL;
                        end else begin
                            MEM_REQ <= 1'b0;
                            state_q <= AMD_S_FIN;
                        end
                    end
                end
                AMD_S_PL: begin
                    if (take) begin
                        pl_q    <= MEM_RDATA;
                        MEM_REQ <= 1'b0;
                        state_q <= AMD_S_FIN;
                    end
                end
                AMD_S_FIN: begin
                    state_q <= AMD_S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Effective address
    // ****************************************
    always_comb begin
        ea_d = `AMD_ADDR_RST;
        unique case (mode)
            AMD_M_INH:      ea_d = `AMD_ADDR_RST;
            AMD_M_IMM:      ea_d = pc_q - 16'h0001;
            AMD_M_DIR_S:    ea_d = {`AMD_PAGE0_HI, b1_q};
            AMD_M_DIR_L:    ea_d = {b1_q, b2_q};
            AMD_M_IDX0:     ea_d = {`AMD_PAGE0_HI, idx};
            AMD_M_IDX_S:    ea_d = {7'h00, {1'b0, b1_q} + {1'b0, idx}};
            AMD_M_IDX_L:    ea_d = {b1_q, b2_q} + {8'h00, idx};
            AMD_M_IND_S:    ea_d = {`AMD_PAGE0_HI, ph_q};
            AMD_M_IND_L:    ea_d = {ph_q, pl_q};
            AMD_M_INDIDX_S: ea_d = {7'h00, {1'b0, ph_q} + {1'b0, idx}};
            AMD_M_INDIDX_L: ea_d = {ph_q, pl_q} + {8'h00, idx};
            AMD_M_REL_D,
            AMD_M_REL_I:    ea_d = `AMD_ADDR_RST;
            AMD_M_BIT_D,
            AMD_M_BITREL_D: ea_d = {`AMD_PAGE0_HI, b1_q};
            AMD_M_BIT_I,
            AMD_M_BITREL_I: ea_d = {`AMD_PAGE0_HI, ph_q};
        endcase
    end

    // Offset source differs between direct and indirect jump-relative forms; both bit-relative forms take b2_q
    always_comb begin
        is_rel  = 1'b1;
        rel_off = `AMD_BYTE_RST;
        unique case (mode)
            AMD_M_REL_D:    rel_off = b1_q;
            AMD_M_REL_I:    rel_off = ph_q;
            AMD_M_BITREL_D,
            AMD_M_BITREL_I: rel_off = b2_q;
            default:        is_rel = 1'b0;
        endcase
    end

    // ****************************************
    // Result registers
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            EA         <= `AMD_ADDR_RST;
            REL_TARGET <= `AMD_ADDR_RST;
            NEXT_PC    <= `AMD_ADDR_RST;
            OPCODE     <= `AMD_BYTE_RST;
            PREBYTE    <= `AMD_PRE_NONE;
            MODE       <= 5'h00;
            GROUP      <= 4'h0;
            LENGTH     <= `AMD_LEN_MIN;
            USE_Y      <= 1'b0;
        end else if (state_q == AMD_S_FIN) begin
            EA         <= ea_d;
            // Target is taken from the address after the whole instruction
            REL_TARGET <= is_rel ? pc_q + {{8{rel_off[7]}}, rel_off} : pc_q;
            NEXT_PC    <= pc_q;
            OPCODE     <= op_q;
            PREBYTE    <= pre_q;
            MODE       <= mode;
            GROUP      <= group;
            LENGTH     <= len_d;
            USE_Y      <= use_y;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DONE <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            DONE <= (state_q == AMD_S_FIN);
            BUSY <= (state_q != AMD_S_IDLE) ? (state_q != AMD_S_FIN) : START;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_word_hi;
        take && (state_q == AMD_S_PH) && ptr_word;
    endsequence

    sequence s_pre_taken;
        take && (state_q == AMD_S_OP) && is_pre && (pre_q == `AMD_PRE_NONE);
    endsequence

    a_req_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("Memory request dropped or moved before ack");

    a_word_order: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_word_hi |=> (state_q == AMD_S_PL) && (MEM_ADDR == $past(MEM_ADDR) + 16'h0001))
        else $error("Word pointer low byte not read at next address");

    a_pre_then_op: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_pre_taken |=> (state_q == AMD_S_OP) && MEM_REQ && (pre_q == $past(MEM_RDATA)))
        else $error("Prebyte not followed by opcode fetch");

    a_dir_page0: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_DIR_S)) |-> (EA[15:8] == `AMD_PAGE0_HI) && (LENGTH >= 3'd2))
        else $error("Short direct address left page zero");

    a_idx0_page0: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_IDX0)) |-> (EA[15:8] == `AMD_PAGE0_HI) && (LENGTH <= 3'd2))
        else $error("No-offset indexed address or length wrong");

    a_short_sum: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE inside {5'(AMD_M_IDX_S), 5'(AMD_M_INDIDX_S)}) |-> (EA <= `AMD_SHORT_MAX))
        else $error("Short indexed sum beyond 1FE");

    a_ind_page0: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_IND_S)) |-> (EA[15:8] == `AMD_PAGE0_HI) && (LENGTH >= 3'd3))
        else $error("Short indirect operand outside page zero");

    a_len_range: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE |-> (LENGTH >= `AMD_LEN_MIN) && (LENGTH <= `AMD_LEN_MAX)
              && (NEXT_PC == $past(pc_q)))
        else $error("Instruction length out of range");

    a_rel_target: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_REL_D)) |-> (REL_TARGET == NEXT_PC + {{8{$past(b1_q[7])}}, $past(b1_q)}))
        else $error("Relative target not PC plus signed offset");

    a_done_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE |-> !BUSY ##1 !DONE)
        else $error("Done not a single pulse");

    a_long_dir: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_DIR_L)) |-> (EA == {b1_q, b2_q}) && (LENGTH >= 3'd3))
        else $error("Long direct address word not used");

    a_idx_long: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_IDX_L)) |-> (EA == {b1_q, b2_q} + {8'h00, (USE_Y ? y_q : x_q)}))
        else $error("Long indexed sum wrong");

    // Wraps in 16 bits, so a pointer near the top lands in page zero
    a_indidx_long: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_INDIDX_L)) |-> (EA == {ph_q, pl_q} + {8'h00, (USE_Y ? y_q : x_q)}))
        else $error("Long indirect-indexed sum wrong");

    a_y_prebyte: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (PREBYTE == `AMD_PRE_Y) |-> USE_Y)
        else $error("Y prebyte did not select Y");

    a_iy_prebyte: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (PREBYTE == `AMD_PRE_IND_Y) && (OPCODE[7:4] == `AMD_HI_IDXS)
        |-> USE_Y && (MODE == 5'(AMD_M_INDIDX_S)))
        else $error("Indirect Y prebyte not indirect-indexed by Y");

    a_short_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (OPCODE[7:4] inside {`AMD_HI_RMW_DIR, `AMD_HI_RMW_IDXS})
        |-> (MODE inside {5'(AMD_M_DIR_S), 5'(AMD_M_IND_S), 5'(AMD_M_IDX_S), 5'(AMD_M_INDIDX_S)}))
        else $error("Read-modify-write decoded in a long mode");

    a_ind_short: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (PREBYTE == `AMD_PRE_IND) && (OPCODE[7:4] == `AMD_HI_DIRS) |-> (MODE == 5'(AMD_M_IND_S)))
        else $error("Indirect prebyte did not select indirect form");

    a_rel_ind: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DONE && (MODE == 5'(AMD_M_REL_I)) |-> (REL_TARGET == NEXT_PC + {{8{ph_q[7]}}, ph_q}))
        else $error("Indirect relative offset not taken from memory");

endmodule
`default_nettype wire

// File: amd_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Memory
// ********
module amd_mem_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Read port
    input  wire logic        req,
    input  wire logic [15:0] addr,
    output logic             ack,
    output logic [7:0]       rdata,
    // Wait states per read
    input  wire logic [1:0]  wait_n
);
    logic [7:0] bytes [0:65535];
    logic [1:0] cnt_q;
    logic [7:0] last_q;
    // Idle data is inverted last byte, so a stale read never matches
    assign ack   = req && cnt_q == wait_n;
    assign rdata = ack ? bytes[addr] : ~last_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 2'h0;
            last_q <= 8'h00;
        end else if (ack) begin
            cnt_q  <= 2'h0;
            last_q <= rdata;
        end else if (req) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    initial foreach (bytes[i]) bytes[i] = 8'h00;
endmodule
`default_nettype wire

// File: amd_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_tb;
    import amd_pkg::*;
    logic CORE_CLK = 0, RST_N = 0, START = 0, MEM_ACK, BUSY, DONE, USE_Y, MEM_REQ;
    logic [15:0] PC_IN = 0, MEM_ADDR, EA, REL_TARGET, NEXT_PC;
    logic [7:0] X_IN = 0, Y_IN = 0, MEM_RDATA, OPCODE, PREBYTE;
    logic [4:0] MODE;
    logic [3:0] GROUP;
    logic [2:0] LENGTH;
    logic [1:0] wait_n = 0;
    int n_errors = 0, compares = 0;
    amd_decoder dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .START(START), .PC_IN(PC_IN), .X_IN(X_IN),
        .Y_IN(Y_IN), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
        .BUSY(BUSY), .DONE(DONE), .EA(EA), .REL_TARGET(REL_TARGET), .NEXT_PC(NEXT_PC), .OPCODE(OPCODE),
        .PREBYTE(PREBYTE), .MODE(MODE), .GROUP(GROUP), .LENGTH(LENGTH), .USE_Y(USE_Y));
    amd_mem_model mem (.clk(CORE_CLK), .rst_n(RST_N), .req(MEM_REQ), .addr(MEM_ADDR), .ack(MEM_ACK),
        .rdata(MEM_RDATA), .wait_n(wait_n));
    always #12.5 CORE_CLK = ~CORE_CLK;
    // ********
    // Helpers
    // ********
    task tally_and_finish;
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk_addr(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t addr %h exp %h", $time, got, exp);
        end
    endtask
    task chk_code(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t code %h exp %h", $time, got, exp);
        end
    endtask
    task prog(input logic [15:0] a, input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) mem.bytes[a + 16'(i)] = w[31 - 8 * i -: 8];
    endtask
    // Bounded wait, since a lost ack would hang the decode
    task go(input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y);
        int n;
        @(posedge CORE_CLK);
        #2;
        START = 1;
        PC_IN = pc;
        X_IN = x;
        Y_IN = y;
        @(posedge CORE_CLK);
        #2;
        START = 0;
        for (n = 0; n < 40 && DONE !== 1'b1; n++) @(posedge CORE_CLK) #2;
        if (n == 40) begin
            n_errors++;
            $display("MISMATCH %0t no done", $time);
        end
    endtask
    // ********
    // Scenarios
    // ********
    task t_direct;
        prog(16'h0100, 32'hb6550000, 2);
        go(16'h0100, 8'h00, 8'h00);
        chk_addr(EA, 16'h0055);
        chk_code({2'h0, LENGTH}, 5'h02);
        prog(16'h0110, 32'h3c550000, 2);
        go(16'h0110, 8'h00, 8'h00);
        chk_code({1'h0, GROUP}, {1'h0, AMD_G_INCDEC});
        chk_code(MODE, AMD_M_DIR_S);
        prog(16'h0120, 32'hc6123400, 3);
        go(16'h0120, 8'h00, 8'h00);
        chk_addr(EA, 16'h1234);
        chk_addr(NEXT_PC, 16'h0123);
    endtask
    task t_indexed;
        prog(16'h0200, 32'h90f60000, 2);
        go(16'h0200, 8'h11, 8'hab);
        chk_addr(EA, 16'h00ab);
        chk_code({4'h0, USE_Y}, 5'h01);
        prog(16'h0210, 32'he6ff0000, 2);
        go(16'h0210, 8'hff, 8'h00);
        chk_addr(EA, 16'h01fe);
        prog(16'h0220, 32'hd6fff000, 3);
        go(16'h0220, 8'h20, 8'h00);
        chk_addr(EA, 16'h0010);
    endtask
    task t_indirect;
        wait_n = 2'h2;
        prog(16'h0300, 32'h92b61000, 3);
        mem.bytes[16'h0010] = 8'h77;
        go(16'h0300, 8'h00, 8'h00);
        chk_addr(EA, 16'h0077);
        chk_code(MODE, AMD_M_IND_S);
        prog(16'h0310, 32'h92c62000, 3);
        prog(16'h0020, 32'h12340000, 2);
        go(16'h0310, 8'h00, 8'h00);
        chk_addr(EA, 16'h1234);
        prog(16'h0320, 32'h91e63000, 3);
        mem.bytes[16'h0030] = 8'hff;
        go(16'h0320, 8'h01, 8'hff);
        chk_addr(EA, 16'h01fe);
        chk_code({4'h0, USE_Y}, 5'h01);
        prog(16'h0330, 32'h92d65000, 3);
        prog(16'h0050, 32'hfff00000, 2);
        go(16'h0330, 8'h20, 8'h00);
        chk_addr(EA, 16'h0010);
        chk_code(MODE, AMD_M_INDIDX_L);
        wait_n = 2'h0;
    endtask
    task t_relative;
        prog(16'h0500, 32'h20fe0000, 2);
        go(16'h0500, 8'h00, 8'h00);
        chk_addr(REL_TARGET, 16'h0500);
        prog(16'h0600, 32'h92274000, 3);
        mem.bytes[16'h0040] = 8'h80;
        go(16'h0600, 8'h00, 8'h00);
        chk_addr(REL_TARGET, 16'h0583);
        prog(16'h0700, 32'h92001005, 4);
        mem.bytes[16'h0010] = 8'h66;
        go(16'h0700, 8'h00, 8'h00);
        chk_code({2'h0, LENGTH}, 5'h04);
        chk_addr(EA, 16'h0066);
        chk_addr(REL_TARGET, 16'h0709);
        chk_addr({PREBYTE, OPCODE}, 16'h9200);
        chk_code({4'h0, BUSY}, 5'h00);
        prog(16'h0800, 32'had100000, 2);
        go(16'h0800, 8'h00, 8'h00);
        chk_addr(REL_TARGET, 16'h0812);
        chk_code({1'h0, GROUP}, {1'h0, AMD_G_JUMP});
    endtask
    initial begin
        #50000;
        n_errors++;
        $display("MISMATCH %0t watchdog", $time);
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge CORE_CLK);
        #2;
        RST_N = 1;
        chk_code({2'h0, LENGTH}, 5'h01);
        t_direct;
        t_indexed;
        t_indirect;
        t_relative;
        tally_and_finish;
    end
endmodule
`default_nettype wire
